// [src/lfp_top.sv]
// Purpose: Indicator pin function select, polarity and mixing logic
// Assumes: Status and timer selects are synchronous to ref_clk_i
// Notes:   Pin outputs and enables are registered
//
// The implementer's own choice: the strobed register port.
`default_nettype none
module lfp_top #(
  parameter int unsigned STRETCH_MIN_CYC = lfp_pkg::STRETCH_CYC,
  parameter int unsigned BLINK_MIN_CYC   = lfp_pkg::BLINK_CYC
) (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  // Register port
  input  wire lfp_pkg::lfp_bus_req_t bus_i,
  output logic [15:0]                rdata_o,
  // Link status and timer selects
  input  wire lfp_pkg::lfp_status_t  status_i,
  input  wire logic [2:0]            stretch_sel_i,
  input  wire logic [2:0]            blink_sel_i,
  // Indicator pins
  output logic [3:0]                 indicator_pin_o,
  output logic [3:0]                 indicator_pin_oe_o
);
  localparam int CW = lfp_pkg::CNT_W;

  logic [15:0]   func_reg, func_next, pol_reg, pol_next;
  logic [15:0]   rdata_reg, rdata_next;
  logic [CW-1:0] str_reg [3];
  logic [CW-1:0] str_next [3];
  logic [CW-1:0] blink_cnt_reg, blink_cnt_next, blink_half;
  logic          blink_reg, blink_next;
  logic [2:0]    slot_reg, slot_next, pwm_reg, pwm_next;
  logic [3:0]    pin_reg, pin_next, oe_reg, oe_next;
  logic [2:0]    raw_act, st_act;
  logic [CW-1:0] str_lim;

  // Lit state of one pin in single mode; returns {hiz, lit}
  function automatic logic [1:0] pin_view(input int idx,
      input logic [3:0] code, input lfp_pkg::lfp_status_t s,
      input logic [2:0] act, input logic blink, input logic spd_blink);
    logic lk, s10, s100, s1000;
    lk    = s.link;
    s10   = s.speed == lfp_pkg::SPD_10;
    s100  = s.speed == lfp_pkg::SPD_100;
    s1000 = s.speed == lfp_pkg::SPD_1000;
    pin_view = 2'h0;
    unique case (code)
      lfp_pkg::FN_LINK: begin
        if (idx == 1)
          pin_view[0] = lk & ~s.fiber;
        else if (idx == 3)
          pin_view[0] = lk & s.fiber;
        else
          pin_view[0] = lk;
      end
      lfp_pkg::FN_LINK_ACT: pin_view[0] = lk & (~act[0] | blink);
      lfp_pkg::FN_ALT2: begin
        if (idx == 0)
          pin_view[0] = spd_blink;
        else if (idx != 2)
          pin_view[0] = lk & (~act[2] | blink);
      end
      lfp_pkg::FN_ACT:       pin_view[0] = act[0];
      lfp_pkg::FN_BLINK_ACT: pin_view[0] = act[0] & blink;
      lfp_pkg::FN_ALT5: begin
        if (idx == 1)
          pin_view[0] = lk & (s100 | s.fiber);
        else if (idx != 3)
          pin_view[0] = act[1];
      end
      lfp_pkg::FN_ALT6: begin
        unique case (idx)
          0:       pin_view[0] = lk & ~s.fiber;
          1:       pin_view[0] = lk & s100;
          2:       pin_view[0] = lk & (s10 | s1000);
          default: pin_view[0] = lk & (s10 | (s1000 & s.master));
        endcase
      end
      lfp_pkg::FN_ALT7: begin
        unique case (idx)
          0:       pin_view[0] = lk & s1000;
          1:       pin_view[0] = lk & s100;
          2:       pin_view[0] = lk & s10;
          default: pin_view[0] = lk & s.full_dup;
        endcase
      end
      lfp_pkg::FN_OFF:   pin_view[0] = 1'b0;
      lfp_pkg::FN_ON:    pin_view[0] = 1'b1;
      lfp_pkg::FN_HIZ:   pin_view[1] = 1'b1;
      lfp_pkg::FN_BLINK: pin_view[0] = blink;
      default:           pin_view    = 2'h0;
    endcase
  endfunction

  // Pair modes; returns {odd_lit, even_lit, mixed}
  function automatic logic [2:0] pair_view(input logic [1:0] mode,
      input lfp_pkg::lfp_status_t s, input logic act, input logic blink);
    logic gate;
    gate      = ~act | blink;
    pair_view = 3'h0;
    unique case (mode)
      2'h0, 2'h1: begin
        if (s.link) begin
          unique case (s.speed)
            lfp_pkg::SPD_1000: pair_view = 3'b010;
            lfp_pkg::SPD_100:  pair_view = 3'b100;
            default:           pair_view = 3'b111;
          endcase
          if (mode == 2'h1 && !gate)
            pair_view = 3'h0;
        end
      end
      2'h2: pair_view = {act, s.link, 1'b0};
      default: pair_view = {s.link & s.fiber, s.link & ~s.fiber, 1'b0};
    endcase
  endfunction

  // Electrical drive from lit state and polarity; returns {oe, level}
  function automatic logic [1:0] drive(input logic hiz, input logic lit,
      input logic [1:0] pol);
    drive[1] = ~hiz & (lit | ~pol[1]);
    drive[0] = pol[0] ? lit : ~lit;
  endfunction

  // Register file
  always_comb begin
    func_next  = func_reg;
    pol_next   = pol_reg;
    rdata_next = 16'h0000;
    if (bus_i.wr && bus_i.addr == lfp_pkg::FUNC_OFS)
      func_next = bus_i.wdata;
    if (bus_i.wr && bus_i.addr == lfp_pkg::POL_OFS)
      pol_next = bus_i.wdata;
    if (bus_i.rd && bus_i.addr == lfp_pkg::FUNC_OFS)
      rdata_next = func_reg;
    if (bus_i.rd && bus_i.addr == lfp_pkg::POL_OFS)
      rdata_next = pol_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      func_reg  <= lfp_pkg::FUNC_RST;
      pol_reg   <= lfp_pkg::POL_RST;
      rdata_reg <= 16'h0000;
    end else begin
      func_reg  <= func_next;
      pol_reg   <= pol_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // Activity stretch and blink timers
  assign raw_act = {status_i.rx_act, status_i.tx_act,
                    status_i.tx_act | status_i.rx_act};
  assign str_lim = (stretch_sel_i == 3'h0) ? '0 :
                   CW'(STRETCH_MIN_CYC) << (stretch_sel_i - 3'h1);
  assign blink_half = (CW'(BLINK_MIN_CYC) << ((blink_sel_i >
                       lfp_pkg::BLINK_SEL_MAX) ? lfp_pkg::BLINK_SEL_MAX :
                       blink_sel_i)) >> 1;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (raw_act[i])
        str_next[i] = str_lim;
      else if (str_reg[i] != '0 && stretch_sel_i != 3'h0)
        str_next[i] = str_reg[i] - CW'(1);
      else
        str_next[i] = '0;
      st_act[i] = raw_act[i] | (str_reg[i] != '0);
    end
    blink_cnt_next = blink_cnt_reg + CW'(1);
    blink_next     = blink_reg;
    slot_next      = slot_reg;
    pwm_next       = pwm_reg + 3'h1;
    if (blink_cnt_reg >= blink_half - CW'(1)) begin
      blink_cnt_next = '0;
      blink_next     = ~blink_reg;
      slot_next      = slot_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 3; i++)
        str_reg[i] <= '0;
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
      slot_reg      <= 3'h0;
      pwm_reg       <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++)
        str_reg[i] <= str_next[i];
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_next;
      slot_reg      <= slot_next;
      pwm_reg       <= pwm_next;
    end
  end

  // Pin state
  always_comb begin
    logic [1:0] nblink;
    logic       spd_blink;
    logic [1:0] view;
    logic [2:0] pv;
    logic       mix_e, mix_o;
    view   = '0;
    pv     = '0;
    nblink = 2'h0;
    if (status_i.link) begin
      unique case (status_i.speed)
        lfp_pkg::SPD_1000: nblink = 2'h3;
        lfp_pkg::SPD_100:  nblink = 2'h2;
        default:           nblink = 2'h1;
      endcase
    end
    spd_blink = ~slot_reg[0] & (slot_reg[2:1] < nblink);
    mix_e = {1'b0, pwm_reg} <
            pol_reg[lfp_pkg::MIX_EVEN_LSB +: 4] ||
            pol_reg[lfp_pkg::MIX_EVEN_LSB +: 4] >= lfp_pkg::MIX_FULL;
    mix_o = {1'b0, pwm_reg} <
            pol_reg[lfp_pkg::MIX_ODD_LSB +: 4] ||
            pol_reg[lfp_pkg::MIX_ODD_LSB +: 4] >= lfp_pkg::MIX_FULL;
    pin_next = '0;
    oe_next  = '0;
    for (int i = 0; i < 4; i += 2) begin
      if (func_reg[i*lfp_pkg::PIN_FN_W + 2 +: 2] == lfp_pkg::PAIR_SEL) begin
        pv = pair_view(func_reg[i*lfp_pkg::PIN_FN_W +: 2], status_i,
                       st_act[0], blink_reg);
        {oe_next[i], pin_next[i]} = drive(1'b0, pv[1] & (~pv[0] | mix_e),
            pol_reg[i*lfp_pkg::PIN_POL_W +: 2]);
        {oe_next[i+1], pin_next[i+1]} = drive(1'b0, pv[2] & (~pv[0] | mix_o),
            pol_reg[(i+1)*lfp_pkg::PIN_POL_W +: 2]);
      end else begin
        for (int j = i; j < i + 2; j++) begin
          view = pin_view(j, func_reg[j*lfp_pkg::PIN_FN_W +: 4], status_i,
                          st_act, blink_reg, spd_blink);
          {oe_next[j], pin_next[j]} = drive(view[1], view[0],
              pol_reg[j*lfp_pkg::PIN_POL_W +: 2]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_reg <= 4'h0;
      oe_reg  <= 4'h0;
    end else begin
      pin_reg <= pin_next;
      oe_reg  <= oe_next;
    end
  end

  assign indicator_pin_o    = pin_reg;
  assign indicator_pin_oe_o = oe_reg;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence pin3_paired_s;
    func_reg[11:10] == lfp_pkg::PAIR_SEL &&
    func_reg[15:12] == lfp_pkg::FN_HIZ;
  endsequence

  sequence pin1_paired_s;
    func_reg[3:2] == lfp_pkg::PAIR_SEL && func_reg[7:4] == lfp_pkg::FN_HIZ;
  endsequence

  sequence act_burst_s;
    status_i.tx_act && stretch_sel_i == 3'h1 ##1 !status_i.tx_act;
  endsequence

  pin3_ignored_a: assert property (pin3_paired_s |=>
    indicator_pin_oe_o[3] || $past(pol_reg[7]))
    else $error("pin 3 went high impedance in pair mode");

  pin1_ignored_a: assert property (pin1_paired_s |=>
    indicator_pin_oe_o[1] || $past(pol_reg[3]))
    else $error("pin 1 went high impedance in pair mode");

  pin_hiz_a: assert property (
    func_reg[15:12] == lfp_pkg::FN_HIZ &&
    func_reg[11:10] != lfp_pkg::PAIR_SEL |=> !indicator_pin_oe_o[3])
    else $error("pin 3 driven under forced high impedance");

  force_on_a: assert property (
    func_reg[7:4] == lfp_pkg::FN_ON && func_reg[3:2] != lfp_pkg::PAIR_SEL
    |=> indicator_pin_oe_o[1] && indicator_pin_o[1] == $past(pol_reg[2]))
    else $error("pin 1 forced on with wrong drive");

  pin3_fiber_a: assert property (
    func_reg[15:12] == lfp_pkg::FN_LINK && pol_reg[7:6] == 2'h1 &&
    func_reg[11:10] != lfp_pkg::PAIR_SEL |=> indicator_pin_o[3] ==
    ($past(status_i.link) && $past(status_i.fiber)))
    else $error("pin 3 fiber indication wrong");

  pin2_ten_a: assert property (
    func_reg[11:8] == lfp_pkg::FN_ALT7 && pol_reg[5:4] == 2'h1 |=>
    indicator_pin_o[2] ==
    ($past(status_i.link) && $past(status_i.speed) == lfp_pkg::SPD_10))
    else $error("pin 2 ten-megabit indication wrong");

  pin0_gig_a: assert property (
    func_reg[3:0] == lfp_pkg::FN_ALT7 && pol_reg[1:0] == 2'h1 |=>
    indicator_pin_o[0] ==
    ($past(status_i.link) && $past(status_i.speed) == lfp_pkg::SPD_1000))
    else $error("pin 0 gigabit indication wrong");

  mix_zero_a: assert property (
    func_reg[3:0] == 4'hC && status_i.link &&
    status_i.speed == lfp_pkg::SPD_10 && pol_reg[11:8] == 4'h0 |=>
    indicator_pin_o[0] == !$past(pol_reg[0]) || !indicator_pin_oe_o[0])
    else $error("even pin lit with zero mix");

  stretch_hold_a: assert property (act_burst_s |->
    str_reg[1] != '0)
    else $error("transmit activity not stretched");

  stretch_off_a: assert property (
    stretch_sel_i == 3'h0 && !status_i.tx_act |=> str_reg[1] == '0)
    else $error("stretch active while disabled");

  blink_bound_a: assert property (
    blink_cnt_reg <= CW'(BLINK_MIN_CYC) << lfp_pkg::BLINK_SEL_MAX)
    else $error("blink counter beyond longest period");

  read_data_a: assert property (
    bus_i.rd && bus_i.addr == lfp_pkg::POL_OFS |=>
    rdata_o == $past(pol_reg))
    else $error("polarity register read back wrong");
endmodule
`default_nettype wire

// [src/lfp_pkg.sv]
// Purpose: Constants and types for the indicator function/polarity block
// Assumes: 40 MHz ref_clk_i; status inputs come from the same clock domain
// Notes:   Contract list below
//
// Contract
// - Pin-2 pair mode makes pin-3 code ignored
// - Pin 3: fiber, 10/1000 master, full duplex
// - Common codes: link/act, activity, blink, forces
// - Pin 2: link, transmit, 10/1000, 10; 0010 reserved
// - Pin-2 codes 11xx select four pair modes
// - Pin-0 pair mode makes pin-1 code ignored
// - Pin 1: copper, receive blink, 100/fiber, 100
// - Pin 0 code 0010 blinks speed count
// - Pin 0: link, transmit, copper, 1000, pairs
// - Two mix percentages, 12.5% steps, up to 100%
// - Polarity sets On/Off drive or tristate
// - Polarity fields at bits 7:0, two per pin
// - Activity stretched 21 ms to 1.34 s; 000 off
// - Blink period 42 to 670 ms selectable
`default_nettype none
package lfp_pkg;
  // Register offsets and reset values
  localparam logic [7:0]  FUNC_OFS     = 8'h10;
  localparam logic [7:0]  POL_OFS      = 8'h11;
  localparam logic [15:0] FUNC_RST     = 16'h1777;
  localparam logic [15:0] POL_RST      = 16'h8800;
  // Field layout
  localparam int          PIN_FN_W     = 4;
  localparam int          PIN_POL_W    = 2;
  localparam int          MIX_EVEN_LSB = 8;
  localparam int          MIX_ODD_LSB  = 12;
  localparam logic [3:0]  MIX_FULL     = 4'h8;
  // Function codes
  localparam logic [3:0]  FN_LINK      = 4'h0;
  localparam logic [3:0]  FN_LINK_ACT  = 4'h1;
  localparam logic [3:0]  FN_ALT2      = 4'h2;
  localparam logic [3:0]  FN_ACT       = 4'h3;
  localparam logic [3:0]  FN_BLINK_ACT = 4'h4;
  localparam logic [3:0]  FN_ALT5      = 4'h5;
  localparam logic [3:0]  FN_ALT6      = 4'h6;
  localparam logic [3:0]  FN_ALT7      = 4'h7;
  localparam logic [3:0]  FN_OFF       = 4'h8;
  localparam logic [3:0]  FN_ON        = 4'h9;
  localparam logic [3:0]  FN_HIZ       = 4'hA;
  localparam logic [3:0]  FN_BLINK     = 4'hB;
  localparam logic [1:0]  PAIR_SEL     = 2'h3;
  // Link speed encoding
  localparam logic [1:0]  SPD_10       = 2'h0;
  localparam logic [1:0]  SPD_100      = 2'h1;
  localparam logic [1:0]  SPD_1000     = 2'h2;
  // Timing
  localparam int          CLK_KHZ      = 40000;
  localparam int          STRETCH_MS   = 21;
  localparam int          BLINK_MS     = 42;
  localparam int          STRETCH_CYC  = STRETCH_MS * CLK_KHZ;
  localparam int          BLINK_CYC    = BLINK_MS * CLK_KHZ;
  localparam logic [2:0]  BLINK_SEL_MAX = 3'h4;
  localparam int          CNT_W        = 28;

  typedef struct packed {
    logic       link;
    logic       fiber;
    logic [1:0] speed;
    logic       full_dup;
    logic       master;
    logic       tx_act;
    logic       rx_act;
  } lfp_status_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } lfp_bus_req_t;
endpackage
`default_nettype wire

// [test/lfp_led_model.sv]
// Purpose: Board indicator LEDs with a pull-up on every pin
// Assumes: A released pin is pulled high by the board
// Notes:   Gives the wire level that the LEDs really see
`default_nettype none
module lfp_led_model (
  // Pins from the device
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] oe_i,
  // Resolved wire level
  output logic      [3:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins where the device lets go of the pin
  assign level_o = (pin_i & oe_i) | ~oe_i;
endmodule
`default_nettype wire

// [test/test_led_function_polarity_control.sv]
// Purpose: Self-checking bench for the indicator function/polarity block
// Assumes: Short stretch and blink counts set by parameter
// Notes:   Register tasks, status table, polarity, blink, stretch, mix
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module test_led_function_polarity_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk_i = 1'b0;
  logic                  rstn_i    = 1'b0;
  lfp_pkg::lfp_bus_req_t bus_i     = '0;
  lfp_pkg::lfp_status_t  status_i  = '0;
  logic [2:0]            stretch_sel_i = 3'h0;
  logic [2:0]            blink_sel_i   = 3'h0;
  logic [15:0]           rdata_o;
  logic [3:0]            indicator_pin_o;
  logic [3:0]            indicator_pin_oe_o;
  logic [3:0]            level;
  logic [1:0]            pv [4];
  logic [15:0]           rd_val;
  int                    fail_count = 0;
  int                    tests_run  = 0;
  int                    n0;
  int                    n1;
  logic                  prev;
  // Status table: function word, status bits, lit pins with polarity 01
  localparam logic [15:0] CF [10] = '{16'h6707, 16'h0656, 16'h7760,
    16'h0533, 16'h8538, 16'hAF98, 16'h80AF, 16'h52C9, 16'h8882, 16'h9E9D};
  localparam logic [7:0]  CS [10] = '{8'hAC, 8'hD0, 8'h80, 8'h02, 8'h01,
    8'hA0, 8'hC0, 8'h80, 8'h00, 8'hA0};
  localparam logic [3:0]  CM [10] = '{4'hB, 4'hA, 4'h5, 4'h7, 4'h2,
    4'h6, 4'h6, 4'h1, 4'h0, 4'h5};

  lfp_top #(.STRETCH_MIN_CYC(8), .BLINK_MIN_CYC(16)) dut (
    .ref_clk_i          (ref_clk_i),
    .rstn_i             (rstn_i),
    .bus_i              (bus_i),
    .rdata_o            (rdata_o),
    .status_i           (status_i),
    .stretch_sel_i      (stretch_sel_i),
    .blink_sel_i        (blink_sel_i),
    .indicator_pin_o    (indicator_pin_o),
    .indicator_pin_oe_o (indicator_pin_oe_o)
  );
  lfp_led_model leds (
    .pin_i   (indicator_pin_o),
    .oe_i    (indicator_pin_oe_o),
    .level_o (level)
  );

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus_i.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus_i.rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic setup(input logic [15:0] f, input logic [15:0] p,
                       input logic [7:0] s);
    wr(lfp_pkg::FUNC_OFS, f);
    wr(lfp_pkg::POL_OFS, p);
    @(posedge ref_clk_i);
    status_i <= lfp_pkg::lfp_status_t'(s);
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic count64();
    n0 = 0;
    n1 = 0;
    prev = indicator_pin_o[0];
    repeat (64) begin
      @(posedge ref_clk_i);
      #1;
      if (indicator_pin_o[0] !== prev) n0++;
      prev = indicator_pin_o[0];
      if (indicator_pin_o[1] === 1'b1) n1++;
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge ref_clk_i);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK(level, 4'hF)
    `CHK(indicator_pin_oe_o, 4'hF)
    rd(lfp_pkg::FUNC_OFS, rd_val);
    `CHK(rd_val, 16'h1777)
    rd(lfp_pkg::POL_OFS, rd_val);
    `CHK(rd_val, 16'h8800)
    wr(8'h12, 16'h5A5A);
    rd(8'h12, rd_val);
    `CHK(rd_val, 16'h0000)
    wr(lfp_pkg::POL_OFS, 16'h37C6);
    rd(lfp_pkg::POL_OFS, rd_val);
    `CHK(rd_val, 16'h37C6)
    @(posedge ref_clk_i);
    #1;
    `CHK(rdata_o, 16'h0000)
    // Link, speed, medium, duplex and activity indications
    for (int i = 0; i < 10; i++) begin
      setup(CF[i], 16'h8855, CS[i]);
      `CHK(indicator_pin_o, CM[i])
      `CHK(indicator_pin_oe_o, 4'hF)
    end
    // Every polarity on each pin position, with force codes and Hi-Z
    for (int v = 0; v < 4; v++) begin
      for (int k = 0; k < 4; k++) pv[k] = 2'(v + k);
      setup(16'hA899, {8'h88, pv[3], pv[2], pv[1], pv[0]}, 8'h00);
      `CHK(level, {1'b1, pv[2][1] | ~pv[2][0], pv[1][0], pv[0][0]})
      `CHK(indicator_pin_oe_o, {1'b0, ~pv[2][1], 2'b11})
    end
    // Force blink at two blink periods
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk_i);
      blink_sel_i <= 3'(s);
      setup(16'h888B, 16'h8855, 8'h00);
      count64();
      `CHK(n0 >= (8 >> s) - 1 && n0 <= (8 >> s) + 1, 1'b1)
    end
    // Activity stretch on, then off
    setup(16'h8883, 16'h8855, 8'h00);
    for (int s = 1; s >= 0; s--) begin
      @(posedge ref_clk_i);
      stretch_sel_i <= 3'(s);
      status_i.tx_act <= 1'b1;
      @(posedge ref_clk_i);
      status_i.tx_act <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      `CHK(indicator_pin_o[0], 1'(s))
      repeat (16) @(posedge ref_clk_i);
      #1;
      `CHK(indicator_pin_o[0], 1'b0)
    end
    // Speed blink at 100 Mbps over one cycle of eight blink slots
    setup(16'h8882, 16'h8855, 8'h90);
    n0 = 0;
    repeat (128) begin
      @(posedge ref_clk_i);
      #1;
      if (indicator_pin_o[0] === 1'b1) n0++;
    end
    `CHK(n0, 32)
    // Pair mode at 10 Mbps: even mix 50 percent, odd mix full
    setup(16'h888C, 16'h8455, 8'h80);
    n1 = 0;
    count64();
    `CHK(n1, 64)
    n0 = 0;
    repeat (64) begin
      @(posedge ref_clk_i);
      #1;
      if (indicator_pin_o[0] === 1'b1) n0++;
    end
    `CHK(n0, 32)
    // Even mix at zero leaves the even pin dark
    setup(16'h888C, 16'h8055, 8'h80);
    `CHK(indicator_pin_o[1:0], 2'b10)
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
